// ===== include/fmot_pkg.sv
// constants, register map and field layout for the fault mask block
package fmot_pkg;
  // bus geometry
  localparam int FMOT_DATA_W = 32;
  localparam int FMOT_ADDR_W = 10;
  localparam int FMOT_REG_W = 26;
  // register indices; byte address is four times the index
  localparam logic [7:0] FMOT_IDX_CFG = 8'h3e;
  localparam logic [7:0] FMOT_IDX_USER = 8'h3f;
  localparam logic [7:0] FMOT_IDX_STAT = 8'h40;
  // field layout of the configuration register
  localparam int FMOT_THR_LSB = 7;
  localparam int FMOT_THR_MSB = 15;
  localparam int FMOT_THR_W = FMOT_THR_MSB - FMOT_THR_LSB + 1;
  localparam int FMOT_NFAULT = 7;
  localparam int FMOT_B_INTERP = 6;
  localparam int FMOT_B_TEMP = 5;
  localparam int FMOT_B_OVOLT = 4;
  localparam int FMOT_B_MEMDB = 3;
  localparam int FMOT_B_UPPER = 2;
  localparam int FMOT_B_LOWER = 1;
  localparam int FMOT_B_WEAK = 0;
  // count of faults arriving from outside the clock domain
  localparam int FMOT_NASYNC = 4;
  // status register layout
  localparam int FMOT_ST_DRIVE = 8;
  localparam int FMOT_ST_ACTIVE = 7;
  // reset values
  localparam logic [FMOT_THR_W-1:0] FMOT_THR_RST = 9'h005;
  localparam logic [FMOT_NFAULT-1:0] FMOT_MASK_RST = 7'h00;
  localparam logic [FMOT_REG_W-1:0] FMOT_USER_RST = 26'h0000000;
  // factory trip point in gauss that the threshold scales from
  localparam int FMOT_FACTORY_GAUSS = 100;
endpackage : fmot_pkg

// ===== design/fmot_top.sv
// fault gating of the output driver, with user word, on avalon-mm
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module fmot_top
  import fmot_pkg::*;
#(
  parameter int AMP_W = 9,
  parameter int ANG_W = 12
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [FMOT_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [FMOT_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [FMOT_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic interp_err_in,
  input wire logic temp_range_err_in,
  input wire logic overvolt_err_in,
  input wire logic mem_double_bit_err_in,
  input wire logic [AMP_W-1:0] field_amp_in,
  input wire logic [ANG_W-1:0] angle_in,
  input wire logic [ANG_W-1:0] angle_upper_in,
  input wire logic [ANG_W-1:0] angle_lower_in,
  output logic weak_field_out,
  output logic out_drive_en_out,
  output logic [FMOT_NFAULT-1:0] fault_active_out
);

  // refused at elaboration: compare widths the logic cannot serve
  if (AMP_W < FMOT_THR_W || AMP_W > 16) begin : g_bad_amp_w
    $error("fmot_top: AMP_W must lie between 9 and 16");
  end
  if (ANG_W < 1 || ANG_W > 16) begin : g_bad_ang_w
    $error("fmot_top: ANG_W must lie between 1 and 16");
  end

  // registers
  logic [FMOT_REG_W-1:0] cfg_ff;
  logic [FMOT_REG_W-1:0] user_ff;
  logic wait_ff;
  logic [FMOT_DATA_W-1:0] rdata_ff;
  // fault path
  logic [FMOT_NASYNC-1:0] async_raw;
  logic [FMOT_NASYNC-1:0] sync1_ff;
  logic [FMOT_NASYNC-1:0] sync2_ff;
  logic weak_ff;
  logic upper_ff;
  logic lower_ff;
  logic drive_en_ff;
  logic [FMOT_NFAULT-1:0] active_ff;
  logic [FMOT_NFAULT-1:0] nxt_fault;
  logic [FMOT_NFAULT-1:0] nxt_unmasked;
  logic [FMOT_NFAULT-1:0] mask;
  logic [FMOT_THR_W-1:0] threshold;
  logic [AMP_W-1:0] threshold_ext;
  // bus decode
  logic req;
  logic take;
  logic [7:0] idx;
  logic idx_ok;
  logic [FMOT_DATA_W-1:0] nxt_rdata;
  logic [FMOT_DATA_W-1:0] bmask;

  assign mask = cfg_ff[FMOT_NFAULT-1:0];
  assign threshold = cfg_ff[FMOT_THR_MSB:FMOT_THR_LSB];
  assign threshold_ext = AMP_W'(threshold);

  // ---------------- avalon-mm slave ----------------
  // every access stalls exactly one cycle; the access completes on the
  // edge where waitrequest is low, so no posted write can be lost
  assign req = avs_read_in | avs_write_in;
  assign take = req & ~wait_ff;
  assign idx = avs_address_in[9:2];
  assign idx_ok = (avs_address_in[1:0] == 2'h0);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bmask[b*8 +: 8] = {8{avs_byteenable_in[b]}};
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_ff <= 1'b1;
    end else if (req && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (idx_ok) begin
      unique case (idx)
        FMOT_IDX_CFG: nxt_rdata = FMOT_DATA_W'(cfg_ff);
        FMOT_IDX_USER: nxt_rdata = FMOT_DATA_W'(user_ff);
        FMOT_IDX_STAT: begin
          nxt_rdata[FMOT_NFAULT-1:0] = active_ff;
          nxt_rdata[FMOT_ST_ACTIVE] = |active_ff;
          nxt_rdata[FMOT_ST_DRIVE] = drive_en_ff;
        end
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // read data is loaded while waitrequest is high and stands with it low
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_ff <= 32'h00000000;
    end else if (avs_read_in && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_ff <= FMOT_REG_W'(0);
      cfg_ff[FMOT_THR_MSB:FMOT_THR_LSB] <= FMOT_THR_RST;
      cfg_ff[FMOT_NFAULT-1:0] <= FMOT_MASK_RST;
    end else if (take && avs_write_in && idx_ok && idx == FMOT_IDX_CFG) begin
      cfg_ff <= FMOT_REG_W'((cfg_ff & ~bmask[FMOT_REG_W-1:0])
        | (avs_writedata_in[FMOT_REG_W-1:0] & bmask[FMOT_REG_W-1:0]));
    end
  end

  // user word is storage only; nothing in the sensor path reads it
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      user_ff <= FMOT_USER_RST;
    end else if (take && avs_write_in && idx_ok && idx == FMOT_IDX_USER)
    begin
      user_ff <= (user_ff & ~bmask[FMOT_REG_W-1:0])
        | (avs_writedata_in[FMOT_REG_W-1:0] & bmask[FMOT_REG_W-1:0]);
    end
  end

  // ---------------- fault path ----------------
  assign async_raw[FMOT_B_INTERP-3] = interp_err_in;
  assign async_raw[FMOT_B_TEMP-3] = temp_range_err_in;
  assign async_raw[FMOT_B_OVOLT-3] = overvolt_err_in;
  assign async_raw[FMOT_B_MEMDB-3] = mem_double_bit_err_in;

  // analog monitors are asynchronous; two flops before any use
  for (genvar g = 0; g < FMOT_NASYNC; g++) begin : g_sync
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        sync1_ff[g] <= 1'b0;
        sync2_ff[g] <= 1'b0;
      end else begin
        sync1_ff[g] <= async_raw[g];
        sync2_ff[g] <= sync1_ff[g];
      end
    end
  end

  // weak field compare; threshold is the raw field, software scales it
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      weak_ff <= 1'b0;
    end else begin
      weak_ff <= (field_amp_in < threshold_ext);
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      upper_ff <= 1'b0;
      lower_ff <= 1'b0;
    end else begin
      upper_ff <= (angle_in > angle_upper_in);
      lower_ff <= (angle_in < angle_lower_in);
    end
  end

  always_comb begin
    nxt_fault = '0;
    nxt_fault[FMOT_B_INTERP] = sync2_ff[FMOT_B_INTERP-3];
    nxt_fault[FMOT_B_TEMP] = sync2_ff[FMOT_B_TEMP-3];
    nxt_fault[FMOT_B_OVOLT] = sync2_ff[FMOT_B_OVOLT-3];
    nxt_fault[FMOT_B_MEMDB] = sync2_ff[FMOT_B_MEMDB-3];
    nxt_fault[FMOT_B_UPPER] = upper_ff;
    nxt_fault[FMOT_B_LOWER] = lower_ff;
    nxt_fault[FMOT_B_WEAK] = weak_ff;
  end

  // a mask bit of one keeps its fault from releasing the driver
  assign nxt_unmasked = nxt_fault & ~mask;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active_ff <= '0;
      drive_en_ff <= 1'b0;
    end else begin
      active_ff <= nxt_fault;
      drive_en_ff <= ~|nxt_unmasked;
    end
  end

  assign avs_waitrequest_out = wait_ff;
  assign avs_readdata_out = rdata_ff;
  assign weak_field_out = weak_ff;
  assign out_drive_en_out = drive_en_ff;
  assign fault_active_out = active_ff;

  // ---------------- assertions ----------------
  sequence s_unmasked_fault(int b);
    nxt_fault[b] && !mask[b];
  endsequence

  sequence s_masked_only;
    nxt_unmasked == '0;
  endsequence

  a_weak_flag_compare: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ##1 weak_ff == ($past(field_amp_in) < $past(threshold_ext)))
    else $error("weak-field flag disagrees with threshold");

  a_interp_tristate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_unmasked_fault(FMOT_B_INTERP) |=> !out_drive_en_out)
    else $error("interpolator fault left output driven");

  a_temp_tristate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_unmasked_fault(FMOT_B_TEMP) |=> !out_drive_en_out)
    else $error("temperature fault left output driven");

  a_ovolt_tristate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    $rose(overvolt_err_in) && !mask[FMOT_B_OVOLT] ##1
      (overvolt_err_in && !mask[FMOT_B_OVOLT]) [*3]
      |-> !out_drive_en_out)
    else $error("overvoltage did not tri-state within three cycles");

  a_memdb_tristate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_unmasked_fault(FMOT_B_MEMDB) |=> !out_drive_en_out)
    else $error("memory fault left output driven");

  a_upper_tristate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (angle_in > angle_upper_in) && !mask[FMOT_B_UPPER] ##1
      !mask[FMOT_B_UPPER] |=> !out_drive_en_out)
    else $error("upper angle fault left output driven");

  a_lower_tristate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (angle_in < angle_lower_in) && !mask[FMOT_B_LOWER] ##1
      !mask[FMOT_B_LOWER] |=> !out_drive_en_out)
    else $error("lower angle fault left output driven");

  a_weak_tristate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_unmasked_fault(FMOT_B_WEAK) |=> !out_drive_en_out)
    else $error("weak field left output driven");

  a_drive_resume: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_masked_only |=> out_drive_en_out)
    else $error("output not driven with no unmasked fault");

  a_user_readback: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    take && avs_read_in && idx_ok && idx == FMOT_IDX_USER
      |-> avs_readdata_out == FMOT_DATA_W'(user_ff))
    else $error("user word read back wrong");

  a_bus_one_wait: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    req && wait_ff |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("waitrequest not low for exactly one cycle");

endmodule : fmot_top

// ===== verification/fmot_top_tb.sv
// self-checking bench for the fault mask block over avalon-mm
`timescale 1ns/1ps
module fmot_top_tb;
  import fmot_pkg::*;
  localparam logic [9:0] A_CFG = 10'h0f8;
  localparam logic [9:0] A_USER = 10'h0fc;
  localparam logic [9:0] A_BAD = 10'h1c0;
  localparam logic [9:0] A_STAT = 10'h100;
  logic mclk_in, nrst_in, avs_read_in, avs_write_in;
  logic [9:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [3:0] avs_byteenable_in;
  logic avs_waitrequest_out, interp_err_in, temp_range_err_in;
  logic overvolt_err_in, mem_double_bit_err_in;
  logic [8:0] field_amp_in;
  logic [11:0] angle_in, angle_upper_in, angle_lower_in;
  logic weak_field_out, out_drive_en_out;
  logic [6:0] fault_active_out;
  int failures, checks;

  fmot_top u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .interp_err_in(interp_err_in), .temp_range_err_in(temp_range_err_in),
    .overvolt_err_in(overvolt_err_in),
    .mem_double_bit_err_in(mem_double_bit_err_in),
    .field_amp_in(field_amp_in), .angle_in(angle_in),
    .angle_upper_in(angle_upper_in), .angle_lower_in(angle_lower_in),
    .weak_field_out(weak_field_out), .out_drive_en_out(out_drive_en_out),
    .fault_active_out(fault_active_out));

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_flag

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 50) begin
      failures++;
      $display("[ERR] %0t bus timeout", $time);
      wrap_up();
    end
  endtask : bus

  // async faults need three edges and the check comes after the fourth, so every path has margin, the angle and weak paths the most
  task automatic set_cond(input int i, input logic v);
    @(posedge mclk_in);
    case (i)
      6: interp_err_in <= v;
      5: temp_range_err_in <= v;
      4: overvolt_err_in <= v;
      3: mem_double_bit_err_in <= v;
      2: angle_in <= v ? 12'h065 : 12'h032;
      1: angle_in <= v ? 12'h009 : 12'h032;
      default: field_amp_in <= v ? 9'h004 : 9'h005;
    endcase
    repeat (4) @(posedge mclk_in);
  endtask : set_cond

  initial begin
    failures = 0;
    checks = 0;
    nrst_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = '0;
    avs_writedata_in = '0;
    avs_byteenable_in = 4'hf;
    {interp_err_in, temp_range_err_in} = 2'h0;
    {overvolt_err_in, mem_double_bit_err_in} = 2'h0;
    field_amp_in = 9'h005;
    angle_in = 12'h032;
    angle_upper_in = 12'h064;
    angle_lower_in = 12'h00a;
    repeat (20) @(posedge mclk_in);
    chk_flag(out_drive_en_out, 1'b0);
    nrst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk_flag(out_drive_en_out, 1'b1);
    bus(1'b0, A_USER, 32'h0, 4'hf);
    chk_word(q, 32'h00000000);
    bus(1'b0, A_CFG, 32'h0, 4'hf);
    chk_word(q, 32'h00000280);
    bus(1'b1, A_USER, 32'hffffffff, 4'hf);
    bus(1'b1, A_USER, 32'h000000aa, 4'h1);
    bus(1'b1, A_BAD, 32'h12345678, 4'hf);
    bus(1'b0, A_USER, 32'h0, 4'hf);
    chk_word(q, 32'h03ffffaa);
    bus(1'b0, A_BAD, 32'h0, 4'hf);
    chk_word(q, 32'h00000000);
    $display("test registers done");
    // each fault alone, unmasked then masked
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 7; i++) begin
        bus(1'b1, A_CFG, 32'h280 | (m[0] << i), 4'hf);
        set_cond(i, 1'b1);
        case (i)
          6: chk_flag(out_drive_en_out, m[0]);
          5: chk_flag(out_drive_en_out, m[0]);
          4: chk_flag(out_drive_en_out, m[0]);
          3: chk_flag(out_drive_en_out, m[0]);
          2: chk_flag(out_drive_en_out, m[0]);
          1: chk_flag(out_drive_en_out, m[0]);
          default: chk_flag(out_drive_en_out, m[0]);
        endcase
        chk_flag(fault_active_out[i], 1'b1);
        if (i == 0) chk_flag(weak_field_out, 1'b1);
        set_cond(i, 1'b0);
        chk_flag(out_drive_en_out, 1'b1);
      end
    end
    $display("test masks done");
    bus(1'b1, A_CFG, 32'h280, 4'hf);
    set_cond(6, 1'b1);
    set_cond(4, 1'b1);
    // status: faults 6 and 4, any-fault bit, driver released
    bus(1'b0, A_STAT, 32'h0, 4'hf);
    chk_word(q, 32'h000000d0);
    bus(1'b1, A_STAT, 32'h000001ff, 4'hf);
    bus(1'b0, A_STAT, 32'h0, 4'hf);
    chk_word(q, 32'h000000d0);
    set_cond(6, 1'b0);
    chk_flag(out_drive_en_out, 1'b0);
    set_cond(4, 1'b0);
    chk_flag(out_drive_en_out, 1'b1);
    // strict limits: equal angles are no fault
    angle_in <= 12'h064;
    repeat (4) @(posedge mclk_in);
    chk_flag(out_drive_en_out, 1'b1);
    angle_in <= 12'h00a;
    repeat (4) @(posedge mclk_in);
    chk_flag(out_drive_en_out, 1'b1);
    angle_in <= 12'h032;
    $display("test combined done");
    // trip point moved to 300 gauss: 5 * 300 / 100 = 15
    bus(1'b1, A_CFG, 32'h780, 4'hf);
    bus(1'b0, A_CFG, 32'h0, 4'hf);
    chk_word(q, 32'h00000780);
    field_amp_in <= 9'h00e;
    repeat (4) @(posedge mclk_in);
    chk_flag(weak_field_out, 1'b1);
    chk_flag(out_drive_en_out, 1'b0);
    field_amp_in <= 9'h00f;
    repeat (4) @(posedge mclk_in);
    chk_flag(weak_field_out, 1'b0);
    chk_flag(out_drive_en_out, 1'b1);
    $display("test threshold done");
    wrap_up();
  end
endmodule : fmot_top_tb
